//--- dv/acp_dev_model.sv
`timescale 1ns/1ps
module acp_dev_model (
    input wire logic serial_enable_n_i,
    input wire logic sclk_i,
    input wire logic serial_in_line_i,
    input wire logic reset_i
);
    logic [7:0]  regs [256];
    logic [15:0] sh;
    int          nbit, nword = 0;
    realtime     t_up, w_rst = 0;
    always @(posedge reset_i) begin
        t_up = $realtime;
        foreach (regs[i]) regs[i] = 8'h00;
    end
    always @(negedge reset_i) w_rst = $realtime - t_up;
    // A new frame drops any unfinished word of the last one.
    always @(negedge serial_enable_n_i) nbit = 0;
    always @(negedge sclk_i) begin
        if (!serial_enable_n_i) begin
            sh = {sh[14:0], serial_in_line_i};
            nbit++;
            if (nbit % 16 == 0) begin
                nword++;
                if (sh[15:8] == 8'h6E && sh[0]) foreach (regs[i]) regs[i] = 8'h00;
                else if (sh[15:8] inside {8'h5D, 8'h62, 8'h63, 8'h65, 8'h68, 8'h69, 8'h6A, 8'h6C, 8'h6D, 8'h7E, 8'h7F})
                    regs[sh[15:8]] = sh[7:0];
            end
        end
    end
endmodule

//--- dv/acp_host_tb.sv
`timescale 1ns/1ps
module acp_host_tb;
    import acp_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, prd, rd;
    logic        rdy, serr, en_n, sclk, sdat, rst;
    int          mismatches = 0, n_checks = 0;
    initial forever #4 clk = ~clk;
    acp_host #(.PWRUP_CYC(20)) dut (.CLK_SYS_I(clk), .NRST_I(nrst), .APB_PSEL_I(psel), .APB_PENABLE_I(pen),
        .APB_PWRITE_I(pwr), .APB_PADDR_I(pa), .APB_PWDATA_I(pwd), .APB_PRDATA_O(prd), .APB_PREADY_O(rdy),
        .APB_PSLVERR_O(serr), .ADC_SERIAL_ENABLE_N_O(en_n), .ADC_SCLK_O(sclk),
        .ADC_SERIAL_IN_LINE_O(sdat), .ADC_RESET_O(rst));
    acp_dev_model dev (.serial_enable_n_i(en_n), .sclk_i(sclk), .serial_in_line_i(sdat), .reset_i(rst));
    task automatic end_sim(input bit hung);
        if (hung) mismatches++;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        int k;
        k = 0;
        psel <= 1'b1;
        pwr <= wr;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1 && ++k < 50);
        if (k >= 50) end_sim(1'b1);
        rd = prd;
        chk(serr, err);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        repeat (2) @(posedge clk);
        do apb(1'b0, REG_STATUS, 32'h0000_0000, 1'b0); while (rd[b] !== v && ++k < 400);
        if (k >= 400) end_sim(1'b1);
    endtask
    task automatic send(input logic [15:0] w, input logic [31:0] cmd, input logic err);
        apb(1'b1, REG_WORD, {16'h0000, w}, 1'b0);
        apb(1'b1, REG_CTRL, cmd, err);
        poll(STAT_BUSY_BIT, 1'b0);
    endtask
    task automatic t_init();
        apb(1'b1, REG_CTRL, 32'h0000_0001, 1'b1);
        apb(1'b0, 8'h0C, 32'h0000_0000, 1'b1);
        chk(rd, 32'h0000_0000);
        poll(STAT_INIT_BIT, 1'b1);
        chk(rd, 32'h0000_000C);
        chk(int'(dev.w_rst), RST_PULSE_CYC * 8);
        apb(1'b1, REG_STATUS, 32'h0000_0008, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0000_0000, 1'b0);
        chk(rd, 32'h0000_0004);
    endtask
    task automatic t_word();
        send(16'h5D01, 32'h0000_0001, 1'b0);
        chk(dev.regs[8'h5D], 8'h01);
        send(16'h63FF, 32'h0000_0001, 1'b0);
        chk(dev.regs[8'h63], 8'h89);
        send(16'h7012, 32'h0000_0001, 1'b1);
        chk(rd, 32'h0000_020C);
        chk(dev.nword, 2);
        apb(1'b0, REG_WORD, 32'h0000_0000, 1'b0);
        chk(rd, 32'h0000_7012);
    endtask
    task automatic t_frame();
        send(16'h6955, 32'h0000_0003, 1'b0);
        send(16'h6AAA, 32'h0000_0003, 1'b0);
        chk(rd, 32'h0000_040E);
        chk(en_n, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0000_0008, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0000_0010, 1'b0);
        poll(STAT_BUSY_BIT, 1'b0);
        chk({dev.regs[8'h69], dev.regs[8'h6A]}, 16'h55AA);
        apb(1'b1, REG_CTRL, 32'h0000_0010, 1'b1);
    endtask
    task automatic t_reset();
        apb(1'b1, REG_CTRL, 32'h0000_0008, 1'b0);
        poll(STAT_BUSY_BIT, 1'b0);
        chk({dev.regs[8'h5D], dev.regs[8'h63], dev.regs[8'h6E]}, 24'h00_0000);
        chk(rst, 1'b0);
        send(16'h5D01, 32'h0000_0001, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0000_0004, 1'b0);
        poll(STAT_INIT_BIT, 1'b1);
        chk(dev.regs[8'h5D], 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_init();
        t_word();
        t_frame();
        t_reset();
        end_sim(1'b0);
    end
endmodule

//--- rtl/acp_host.sv
`timescale 1ns/1ps
// Operation
// - Data stable at every falling shift edge.
// - Several words may share one enable frame.
// - Address byte first, then data byte.
// - Shift clock at most twenty megahertz.
// - Initialise by reset pulse over ten ns.
// - Reset pin stays low during serial access.
// - Reset pulse no longer than one microsecond.
// - Parallel mode needs reset pin held high.
// - Wait 25 ns after reset before enable.
// - Wait 5 ms after power before reset.
// - Unassigned register bits are written zero.
module acp_host #(
    parameter int PWRUP_CYC = acp_pkg::PWRUP_CYC_DEF
) (
    input  wire logic                        CLK_SYS_I,
    input  wire logic                        NRST_I,
    input  wire logic                        APB_PSEL_I,
    input  wire logic                        APB_PENABLE_I,
    input  wire logic                        APB_PWRITE_I,
    input  wire logic [acp_pkg::APB_AW-1:0]  APB_PADDR_I,
    input  wire logic [acp_pkg::APB_DW-1:0]  APB_PWDATA_I,
    output logic      [acp_pkg::APB_DW-1:0]  APB_PRDATA_O,
    output logic                             APB_PREADY_O,
    output logic                             APB_PSLVERR_O,
    output logic                             ADC_SERIAL_ENABLE_N_O,
    output logic                             ADC_SCLK_O,
    output logic                             ADC_SERIAL_IN_LINE_O,
    output logic                             ADC_RESET_O
);
    import acp_pkg::*;

    localparam logic [WAIT_W-1:0] PWRUP_LOAD = WAIT_W'(PWRUP_CYC - 1);
    localparam logic [WAIT_W-1:0] PULSE_LOAD = WAIT_W'(RST_PULSE_CYC - 1);
    localparam logic [WAIT_W-1:0] GAP_LOAD   = WAIT_W'(RST_TO_EN_CYC - 1);

    acp_state_e             state_reg;
    acp_pins_s              pins_reg;
    logic [WAIT_W-1:0]      wait_reg;
    logic [3:0]             bit_cnt_reg;
    logic                   hold_reg;
    logic                   sw_reg;
    logic                   init_done_reg;
    logic [STAT_CNT_W-1:0]  sent_cnt_reg;
    logic                   err_reg;
    logic [WORD_W-1:0]      word_reg;
    logic [APB_DW-1:0]      prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   cmd_send_reg;
    logic                   cmd_hold_reg;
    logic                   cmd_hwrst_reg;
    logic                   cmd_swrst_reg;
    logic                   cmd_close_reg;
    logic                   tick;
    logic                   run;
    logic                   sh_load;
    logic                   sh_shift;
    logic                   sh_msb;
    logic [WORD_W-1:0]      sh_data;
    logic [8:0]             word_mask;
    logic                   ctrl_bad;
    logic                   apb_setup;
    logic                   apb_access;
    logic                   ctrl_wr;
    logic                   is_idle;
    logic                   is_open;
    logic                   cmd_pend;

    assign is_idle    = (state_reg == S_IDLE);
    assign is_open    = (state_reg == S_OPEN);
    assign cmd_pend   = cmd_send_reg || cmd_hwrst_reg || cmd_swrst_reg || cmd_close_reg;
    assign word_mask  = acp_field_mask(word_reg[15:8]);
    assign apb_setup  = APB_PSEL_I && !APB_PENABLE_I;
    assign apb_access = APB_PSEL_I && APB_PENABLE_I && pready_reg;
    assign ctrl_wr    = apb_access && APB_PWRITE_I && (APB_PADDR_I == REG_CTRL);

    // A command the sequencer cannot take in its present state is refused as a whole.
    always_comb begin
        ctrl_bad = 1'b0;
        if (APB_PWDATA_I[CTRL_HWRST_BIT]) begin
            ctrl_bad = !is_idle || cmd_pend;
        end else if (APB_PWDATA_I[CTRL_SWRST_BIT]) begin
            ctrl_bad = !is_idle || cmd_pend;
        end else if (APB_PWDATA_I[CTRL_CLOSE_BIT]) begin
            ctrl_bad = !is_open || cmd_pend;
        end else if (APB_PWDATA_I[CTRL_SEND_BIT]) begin
            ctrl_bad = !(is_idle || is_open) || cmd_pend || !word_mask[8];
        end
    end

    // Bus slave: answers with zero wait states, read data and error are prepared in setup.
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pready_reg    <= 1'b0;
            prdata_reg    <= '0;
            pslverr_reg   <= 1'b0;
            word_reg      <= WORD_RESET;
            cmd_send_reg  <= 1'b0;
            cmd_hold_reg  <= 1'b0;
            cmd_hwrst_reg <= 1'b0;
            cmd_swrst_reg <= 1'b0;
            cmd_close_reg <= 1'b0;
        end else begin
            pready_reg    <= 1'b1;
            cmd_send_reg  <= 1'b0;
            cmd_hwrst_reg <= 1'b0;
            cmd_swrst_reg <= 1'b0;
            cmd_close_reg <= 1'b0;
            if (apb_setup) begin
                prdata_reg  <= '0;
                pslverr_reg <= 1'b0;
                if (APB_PADDR_I == REG_CTRL) begin
                    pslverr_reg <= APB_PWRITE_I && ctrl_bad;
                end else if (APB_PADDR_I == REG_WORD) begin
                    prdata_reg[WORD_W-1:0] <= word_reg;
                end else if (APB_PADDR_I == REG_STATUS) begin
                    prdata_reg[STAT_BUSY_BIT] <= !(is_idle || is_open);
                    prdata_reg[STAT_OPEN_BIT] <= is_open;
                    prdata_reg[STAT_INIT_BIT] <= init_done_reg;
                    prdata_reg[STAT_ERR_BIT]  <= err_reg;
                    prdata_reg[STAT_CNT_LSB +: STAT_CNT_W] <= sent_cnt_reg;
                end else begin
                    pslverr_reg <= 1'b1;
                end
            end
            if (apb_access && APB_PWRITE_I && APB_PADDR_I == REG_WORD) begin
                word_reg <= APB_PWDATA_I[WORD_W-1:0];
            end
            // The verdict reported in setup is the one applied, so error and action never disagree.
            if (ctrl_wr && !pslverr_reg) begin
                cmd_hold_reg <= APB_PWDATA_I[CTRL_HOLD_BIT];
                if (APB_PWDATA_I[CTRL_HWRST_BIT]) begin
                    cmd_hwrst_reg <= 1'b1;
                end else if (APB_PWDATA_I[CTRL_SWRST_BIT]) begin
                    cmd_swrst_reg <= 1'b1;
                end else if (APB_PWDATA_I[CTRL_CLOSE_BIT]) begin
                    cmd_close_reg <= 1'b1;
                end else if (APB_PWDATA_I[CTRL_SEND_BIT]) begin
                    cmd_send_reg <= 1'b1;
                end
            end
        end
    end

    // Sticky refusal flag, cleared by writing one; a new refusal wins over the clear.
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            err_reg <= 1'b0;
        end else if (ctrl_wr && pslverr_reg) begin
            err_reg <= 1'b1;
        end else if (apb_access && APB_PWRITE_I && APB_PADDR_I == REG_STATUS && APB_PWDATA_I[STAT_ERR_BIT]) begin
            err_reg <= 1'b0;
        end
    end

    assign run      = (state_reg == S_SHIFT) || (state_reg == S_TAIL) || (state_reg == S_GAPHI);
    assign sh_load  = (is_idle && (cmd_swrst_reg || cmd_send_reg)) || (is_open && cmd_send_reg);
    assign sh_shift = (state_reg == S_SHIFT) && tick && !pins_reg.sclk;
    // Address leads, and only the assigned data bits can be sent as one.
    assign sh_data  = cmd_swrst_reg ? {SOFT_RST_ADDR, SOFT_RST_VAL}
                                    : {word_reg[15:8], word_reg[7:0] & word_mask[7:0]};

    acp_sclk_div #(
        .HALF   (SCLK_HALF_CYC)
    ) u_div (
        .clk_i  (CLK_SYS_I),
        .nrst_i (NRST_I),
        .run_i  (run),
        .tick_o (tick)
    );

    acp_shifter #(
        .WIDTH   (WORD_W)
    ) u_sh (
        .clk_i   (CLK_SYS_I),
        .nrst_i  (NRST_I),
        .load_i  (sh_load),
        .data_i  (sh_data),
        .shift_i (sh_shift),
        .msb_o   (sh_msb)
    );

    // Sequencer: power-up wait, reset pulse, reset-to-enable gap, then word framing.
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_reg     <= S_PWRUP;
            pins_reg      <= PINS_IDLE;
            wait_reg      <= PWRUP_LOAD;
            bit_cnt_reg   <= 4'h0;
            hold_reg      <= 1'b0;
            sw_reg        <= 1'b0;
            init_done_reg <= 1'b0;
            sent_cnt_reg  <= '0;
        end else begin
            case (state_reg)
                S_PWRUP: begin
                    if (wait_reg == '0) begin
                        pins_reg.reset <= 1'b1;
                        wait_reg       <= PULSE_LOAD;
                        state_reg      <= S_RSTHI;
                    end else begin
                        wait_reg <= wait_reg - 1'b1;
                    end
                end
                S_RSTHI: begin
                    if (wait_reg == '0) begin
                        pins_reg.reset <= 1'b0;
                        wait_reg       <= GAP_LOAD;
                        state_reg      <= S_RSTGAP;
                    end else begin
                        wait_reg <= wait_reg - 1'b1;
                    end
                end
                S_RSTGAP: begin
                    if (wait_reg == '0) begin
                        init_done_reg <= 1'b1;
                        state_reg     <= S_IDLE;
                    end else begin
                        wait_reg <= wait_reg - 1'b1;
                    end
                end
                S_IDLE, S_OPEN: begin
                    if (cmd_hwrst_reg) begin
                        init_done_reg  <= 1'b0;
                        pins_reg.reset <= 1'b1;
                        wait_reg       <= PULSE_LOAD;
                        state_reg      <= S_RSTHI;
                    end else if (cmd_close_reg) begin
                        state_reg <= S_TAIL;
                    end else if (sh_load) begin
                        pins_reg.serial_enable_n <= 1'b0;
                        hold_reg    <= cmd_hold_reg && !cmd_swrst_reg;
                        sw_reg      <= cmd_swrst_reg;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (tick && !pins_reg.sclk) begin
                        pins_reg.sclk           <= 1'b1;
                        pins_reg.serial_in_line <= sh_msb;
                    end else if (tick) begin
                        pins_reg.sclk <= 1'b0;
                        bit_cnt_reg   <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg == 4'hF) begin
                            sent_cnt_reg <= sent_cnt_reg + 1'b1;
                            if (sw_reg) begin
                                init_done_reg <= 1'b1;
                                sw_reg        <= 1'b0;
                            end
                            state_reg <= hold_reg ? S_OPEN : S_TAIL;
                        end
                    end
                end
                S_TAIL: begin
                    if (tick) begin
                        pins_reg.serial_enable_n <= 1'b1;
                        pins_reg.serial_in_line  <= 1'b0;
                        state_reg                <= S_GAPHI;
                    end
                end
                S_GAPHI: begin
                    if (tick) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign APB_PRDATA_O          = prdata_reg;
    assign APB_PREADY_O          = pready_reg;
    assign APB_PSLVERR_O         = pslverr_reg;
    assign ADC_SERIAL_ENABLE_N_O = pins_reg.serial_enable_n;
    assign ADC_SCLK_O            = pins_reg.sclk;
    assign ADC_SERIAL_IN_LINE_O  = pins_reg.serial_in_line;
    assign ADC_RESET_O           = pins_reg.reset;

    // Helper state watched only by the checks below.
    logic [3:0]        fall_cnt_reg;
    logic [7:0]        rst_hi_cnt_reg;
    logic [3:0]        rst_lo_cnt_reg;
    logic [WAIT_W-1:0] pwr_cnt_reg;
    logic [WORD_W-1:0] tx_word_reg;
    logic [8:0]        tx_mask;

    assign tx_mask = acp_field_mask(tx_word_reg[15:8]);

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fall_cnt_reg   <= 4'h0;
            rst_hi_cnt_reg <= 8'h00;
            rst_lo_cnt_reg <= 4'h0;
            pwr_cnt_reg    <= '0;
            tx_word_reg    <= WORD_RESET;
        end else begin
            if (pins_reg.serial_enable_n) begin
                fall_cnt_reg <= 4'h0;
            end else if ((state_reg == S_SHIFT) && tick && pins_reg.sclk) begin
                fall_cnt_reg <= fall_cnt_reg + 1'b1;
            end
            if (!pins_reg.reset) begin
                rst_hi_cnt_reg <= 8'h00;
            end else if (rst_hi_cnt_reg != 8'hFF) begin
                rst_hi_cnt_reg <= rst_hi_cnt_reg + 1'b1;
            end
            if (pins_reg.reset) begin
                rst_lo_cnt_reg <= 4'h0;
            end else if (rst_lo_cnt_reg != 4'hF) begin
                rst_lo_cnt_reg <= rst_lo_cnt_reg + 1'b1;
            end
            if (pwr_cnt_reg != WAIT_W'(PWRUP_CYC)) begin
                pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
            end
            if (sh_load) begin
                tx_word_reg <= sh_data;
            end
        end
    end

    AST_SCLK_IDLE: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        pins_reg.serial_enable_n |-> !pins_reg.sclk)
        else $error("Shift clock high while enable is inactive.");

    AST_DATA_STABLE: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $fell(pins_reg.sclk) |-> $stable(pins_reg.serial_in_line) && ($past(pins_reg.serial_in_line, 3) == pins_reg.serial_in_line))
        else $error("Data line moved near a falling shift edge.");

    AST_WHOLE_WORDS: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(pins_reg.serial_enable_n) |-> (fall_cnt_reg == 4'h0))
        else $error("Frame closed after a partial word.");

    AST_BIT_ORDER: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(pins_reg.sclk) |-> (pins_reg.serial_in_line == tx_word_reg[4'hF - bit_cnt_reg]))
        else $error("Bit on the line does not match the word order.");

    AST_SCLK_HIGH: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(pins_reg.sclk) |-> pins_reg.sclk [*4])
        else $error("Shift clock high phase too short.");

    AST_SCLK_LOW: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $fell(pins_reg.sclk) |-> (!pins_reg.sclk) [*4])
        else $error("Shift clock low phase too short.");

    AST_RST_WIDTH: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $fell(pins_reg.reset) |-> (rst_hi_cnt_reg >= 8'(RST_MIN_CYC)) && (rst_hi_cnt_reg <= 8'(RST_MAX_CYC)))
        else $error("Reset pulse width out of range.");

    AST_RST_LOW_IN_FRAME: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        !pins_reg.serial_enable_n |-> !pins_reg.reset)
        else $error("Reset pin high during a serial frame.");

    AST_RST_TO_ENABLE: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $fell(pins_reg.serial_enable_n) |-> (rst_lo_cnt_reg >= 4'(RST_TO_EN_CYC)))
        else $error("Enable fell too soon after reset.");

    AST_PWRUP_WAIT: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        $rose(pins_reg.reset) |-> (pwr_cnt_reg >= WAIT_W'(PWRUP_CYC)))
        else $error("Reset pulse issued before power-up wait ended.");

    AST_ZERO_UNUSED: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
        ($rose(pins_reg.sclk) && bit_cnt_reg == 4'h0) |-> ((tx_word_reg[7:0] & ~tx_mask[7:0]) == 8'h00))
        else $error("Unassigned data bit sent as one.");

endmodule

//--- rtl/acp_pkg.sv
package acp_pkg;

    // Clock and timing figures, each derived count sits next to its figure.
    localparam int CLK_KHZ         = 125000;
    localparam int SCLK_MAX_KHZ    = 20000;
    localparam int SCLK_HALF_CYC   = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
    localparam int RST_MIN_NS      = 10;
    localparam int RST_MIN_CYC     = (RST_MIN_NS * CLK_KHZ) / 1000000 + 1;
    localparam int RST_MAX_NS      = 1000;
    localparam int RST_MAX_CYC     = (RST_MAX_NS * CLK_KHZ) / 1000000;
    localparam int RST_PULSE_NS    = 500;
    localparam int RST_PULSE_CYC   = (RST_PULSE_NS * CLK_KHZ) / 1000000;
    localparam int RST_TO_EN_NS    = 25;
    localparam int RST_TO_EN_CYC   = (RST_TO_EN_NS * CLK_KHZ + 999999) / 1000000;
    localparam int PWRUP_MS        = 5;
    localparam int PWRUP_CYC_DEF   = PWRUP_MS * CLK_KHZ;
    localparam int WAIT_W          = 20;

    // Register bus of the controller.
    localparam int APB_AW          = 8;
    localparam int APB_DW          = 32;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_WORD   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_SEND_BIT   = 0;
    localparam int CTRL_HOLD_BIT   = 1;
    localparam int CTRL_HWRST_BIT  = 2;
    localparam int CTRL_SWRST_BIT  = 3;
    localparam int CTRL_CLOSE_BIT  = 4;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_OPEN_BIT   = 1;
    localparam int STAT_INIT_BIT   = 2;
    localparam int STAT_ERR_BIT    = 3;
    localparam int STAT_CNT_LSB    = 8;
    localparam int STAT_CNT_W      = 8;
    localparam int WORD_W          = 16;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Device register map and the bits each register really uses.
    localparam logic [7:0] ADDR_NOISE_SUPPRESS = 8'h5D;
    localparam logic [7:0] ADDR_STROBE_POS     = 8'h62;
    localparam logic [7:0] ADDR_PWR_FMT_SPEED  = 8'h63;
    localparam logic [7:0] ADDR_TEST_PATTERN   = 8'h65;
    localparam logic [7:0] ADDR_FINE_GAIN      = 8'h68;
    localparam logic [7:0] ADDR_USER_PAT_LOW   = 8'h69;
    localparam logic [7:0] ADDR_USER_PAT_HIGH  = 8'h6A;
    localparam logic [7:0] ADDR_OUT_PORT_SEL   = 8'h6C;
    localparam logic [7:0] ADDR_BIAS_SOURCE    = 8'h6D;
    localparam logic [7:0] ADDR_SOFT_REINIT    = 8'h6E;
    localparam logic [7:0] ADDR_LVDS_TERM      = 8'h7E;
    localparam logic [7:0] ADDR_LVDS_DRIVE     = 8'h7F;
    localparam int          LOW_BAND_NOISE_CUT_BIT = 0;
    localparam logic [7:0] SOFT_RST_ADDR = ADDR_SOFT_REINIT;
    localparam logic [7:0] SOFT_RST_VAL  = 8'h01;

    typedef struct packed {
        logic reset;
        logic serial_enable_n;
        logic sclk;
        logic serial_in_line;
    } acp_pins_s;

    localparam acp_pins_s PINS_IDLE = 4'h4;

    typedef enum logic [3:0] {
        S_PWRUP  = 4'h0,
        S_RSTHI  = 4'h1,
        S_RSTGAP = 4'h2,
        S_IDLE   = 4'h3,
        S_SHIFT  = 4'h4,
        S_OPEN   = 4'h5,
        S_TAIL   = 4'h6,
        S_GAPHI  = 4'h7
    } acp_state_e;

    // Returns a known flag above the mask of assigned bits for one address.
    function automatic logic [8:0] acp_field_mask(input logic [7:0] addr);
        logic [8:0] r;
        r = 9'h000;
        if (addr == ADDR_NOISE_SUPPRESS) r = 9'h101;
        else if (addr == ADDR_STROBE_POS) r = 9'h11F;
        else if (addr == ADDR_PWR_FMT_SPEED) r = 9'h189;
        else if (addr == ADDR_TEST_PATTERN) r = 9'h1E0;
        else if (addr == ADDR_FINE_GAIN) r = 9'h10F;
        else if (addr == ADDR_USER_PAT_LOW) r = 9'h1FF;
        else if (addr == ADDR_USER_PAT_HIGH) r = 9'h1FF;
        else if (addr == ADDR_OUT_PORT_SEL) r = 9'h11A;
        else if (addr == ADDR_BIAS_SOURCE) r = 9'h110;
        else if (addr == ADDR_SOFT_REINIT) r = 9'h101;
        else if (addr == ADDR_LVDS_TERM) r = 9'h1FF;
        else if (addr == ADDR_LVDS_DRIVE) r = 9'h1FF;
        return r;
    endfunction

endpackage

//--- rtl/acp_sclk_div.sv
`timescale 1ns/1ps
module acp_sclk_div #(
    parameter int HALF = acp_pkg::SCLK_HALF_CYC
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt_reg;

    // Counting restarts whenever run drops, so the first tick is a full half period away.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
        end else if (!run_i || cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick_o = run_i && (cnt_reg == LAST);
endmodule

//--- rtl/acp_shifter.sv
`timescale 1ns/1ps
module acp_shifter #(
    parameter int WIDTH = acp_pkg::WORD_W
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             shift_i,
    output logic                  msb_o
);
    logic [WIDTH-1:0] sh_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_reg <= '0;
        end else if (load_i) begin
            sh_reg <= data_i;
        end else if (shift_i) begin
            sh_reg <= {sh_reg[WIDTH-2:0], 1'b0};
        end
    end

    assign msb_o = sh_reg[WIDTH-1];
endmodule
